// File: drr_pkg.sv
// constants and types shared by the dual-range signal strength readout
package drr_pkg;

    // ==========================================================
    // register indices (byte address = index * 4)
    localparam logic [7:0] IDX_MEASURED_VALUE = 8'h68;
    localparam logic [7:0] IDX_UPDATE_FLAGS   = 8'h6F;
    localparam logic [7:0] IDX_RANGE_CONFIG   = 8'h8B;
    localparam logic [7:0] IDX_SHIFT_CONFIG   = 8'h8F;
    localparam logic [7:0] IDX_FINE_GAIN      = 8'h98;
    localparam logic [7:0] IDX_COARSE_GAIN    = 8'h9C;
    localparam logic [7:0] IDX_FINE_OFFSET    = 8'hA8;
    localparam logic [7:0] IDX_COARSE_OFFSET  = 8'hAC;
    localparam logic [7:0] IDX_FINE_CEILING   = 8'hB0;
    localparam logic [7:0] IDX_COARSE_FLOOR   = 8'hB1;

    // ==========================================================
    // field positions
    localparam int FORCE_FINE_BIT   = 0;
    localparam int FORCE_COARSE_BIT = 1;
    localparam int XOVER_EN_BIT     = 2;
    localparam int INDICATOR_BIT    = 0;
    localparam int NEW_RESULT_BIT   = 1;
    localparam int FINE_SHIFT_LSB   = 0;
    localparam int COARSE_SHIFT_LSB = 4;
    localparam int GAIN_FRAC_BITS   = 15;

    // ==========================================================
    // values after reset
    localparam logic [15:0] RST_GAIN       = 16'h8000;
    localparam logic [15:0] RST_OFFSET     = 16'h0000;
    localparam logic [15:0] RST_CEILING    = 16'hFFFF;
    localparam logic [15:0] RST_FLOOR      = 16'h0000;
    localparam logic [7:0]  RST_RANGE_CFG  = 8'h00;
    localparam logic [7:0]  RST_SHIFT_CFG  = 8'h00;

    // ==========================================================
    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ==========================================================
    // hysteresis thresholds indexed by shift count
    localparam logic [15:0] FINE_MAX [8] = '{16'hFFF8, 16'h7FFC, 16'h3FFE, 16'h1FFF,
                                             16'h0FFF, 16'h07FF, 16'h03FF, 16'h01FF};
    localparam logic [15:0] COARSE_MIN [8] = '{16'hF000, 16'h7800, 16'h3C00, 16'h1E00,
                                               16'h0F00, 16'h0780, 16'h03C0, 16'h01E0};

    typedef enum logic [0:0]
    {
        RANGE_FINE   = 1'b0,
        RANGE_COARSE = 1'b1
    } drr_range_type;

endpackage

// File: drr_cal_unit.sv
// gain and offset calibration of one range, saturated to 16 bits
`timescale 1ns/10ps
module drr_cal_unit
(
    input  wire logic [15:0] raw,
    input  wire logic [15:0] gain,
    input  wire logic [15:0] offset,
    output logic      [15:0] cal
);
    logic        [31:0] product;
    logic signed [17:0] sum;

    // gain is unsigned with 15 fraction bits; offset is two's complement
    always_comb
    begin
        product = raw * gain;
        sum     = $signed({1'b0, product[31:drr_pkg::GAIN_FRAC_BITS]})
                + $signed({{2{offset[15]}}, offset});
        if (sum < 18'sd0)
            cal = 16'h0000;
        else if (sum > $signed({2'b00, 16'hFFFF}))
            cal = 16'hFFFF;
        else
            cal = sum[15:0];
    end
endmodule

// File: drr_readout.sv
// dual-range signal strength readout with axi4-lite registers
// ==========================================================
`timescale 1ns/10ps
module drr_readout
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] fine_raw,
    input  wire logic [15:0] coarse_raw,
    input  wire logic        conv_valid,
    output logic [15:0]      result_value,
    output logic             result_valid,
    output logic             received_signal_strength_range_indicator
);
    // ==========================================================
    // registers
    logic [15:0] fine_range_gain;
    logic [15:0] coarse_range_gain;
    logic [15:0] fine_range_offset;
    logic [15:0] coarse_range_offset;
    logic [15:0] fine_ceiling_limit;
    logic [15:0] coarse_floor_limit;
    logic [7:0]  received_signal_strength_range_config;
    logic [7:0]  shift_count_config;
    logic        new_result;

    // ==========================================================
    // axi write channel
    logic [7:0]  aw_index;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic        wr_fire;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aw_held  <= 1'b0;
            aw_index <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held  <= 1'b1;
            aw_index <= s_axi_awaddr[9:2];
        end
        else if (wr_fire)
            aw_held <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held <= 1'b0;
    end

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == drr_pkg::IDX_MEASURED_VALUE) || (idx == drr_pkg::IDX_UPDATE_FLAGS)
                 || (idx == drr_pkg::IDX_RANGE_CONFIG) || (idx == drr_pkg::IDX_SHIFT_CONFIG)
                 || (idx == drr_pkg::IDX_FINE_GAIN) || (idx == drr_pkg::IDX_COARSE_GAIN)
                 || (idx == drr_pkg::IDX_FINE_OFFSET) || (idx == drr_pkg::IDX_COARSE_OFFSET)
                 || (idx == drr_pkg::IDX_FINE_CEILING) || (idx == drr_pkg::IDX_COARSE_FLOOR);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old);
        merge16 = {w_strb[1] ? w_data[15:8] : old[15:8], w_strb[0] ? w_data[7:0] : old[7:0]};
    endfunction

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= drr_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_index) ? drr_pkg::RESP_OKAY : drr_pkg::RESP_DECERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // separate gains and offsets per range, one shift register for both
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fine_range_gain     <= drr_pkg::RST_GAIN;
            coarse_range_gain   <= drr_pkg::RST_GAIN;
            fine_range_offset   <= drr_pkg::RST_OFFSET;
            coarse_range_offset <= drr_pkg::RST_OFFSET;
            fine_ceiling_limit  <= drr_pkg::RST_CEILING;
            coarse_floor_limit  <= drr_pkg::RST_FLOOR;
            received_signal_strength_range_config   <= drr_pkg::RST_RANGE_CFG;
            shift_count_config  <= drr_pkg::RST_SHIFT_CFG;
        end
        else if (wr_fire)
        begin
            unique case (aw_index)
                drr_pkg::IDX_FINE_GAIN:     fine_range_gain <= merge16(fine_range_gain);
                drr_pkg::IDX_COARSE_GAIN:   coarse_range_gain <= merge16(coarse_range_gain);
                drr_pkg::IDX_FINE_OFFSET:   fine_range_offset <= merge16(fine_range_offset);
                drr_pkg::IDX_COARSE_OFFSET: coarse_range_offset <= merge16(coarse_range_offset);
                drr_pkg::IDX_FINE_CEILING:  fine_ceiling_limit <= merge16(fine_ceiling_limit);
                drr_pkg::IDX_COARSE_FLOOR:  coarse_floor_limit <= merge16(coarse_floor_limit);
                drr_pkg::IDX_RANGE_CONFIG:
                    if (w_strb[0])
                        received_signal_strength_range_config <= w_data[7:0];
                drr_pkg::IDX_SHIFT_CONFIG:
                    if (w_strb[0])
                        shift_count_config <= w_data[7:0];
                default:
                    ;
            endcase
        end
    end

    // ==========================================================
    // axi read channel
    logic [31:0] next_rdata;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (s_axi_araddr[9:2])
            drr_pkg::IDX_MEASURED_VALUE: next_rdata[15:0] = result_value;
            drr_pkg::IDX_UPDATE_FLAGS:
            begin
                next_rdata[drr_pkg::INDICATOR_BIT]  = received_signal_strength_range_indicator;
                next_rdata[drr_pkg::NEW_RESULT_BIT] = new_result;
            end
            drr_pkg::IDX_RANGE_CONFIG:   next_rdata[7:0]  = received_signal_strength_range_config;
            drr_pkg::IDX_SHIFT_CONFIG:   next_rdata[7:0]  = shift_count_config;
            drr_pkg::IDX_FINE_GAIN:      next_rdata[15:0] = fine_range_gain;
            drr_pkg::IDX_COARSE_GAIN:    next_rdata[15:0] = coarse_range_gain;
            drr_pkg::IDX_FINE_OFFSET:    next_rdata[15:0] = fine_range_offset;
            drr_pkg::IDX_COARSE_OFFSET:  next_rdata[15:0] = coarse_range_offset;
            drr_pkg::IDX_FINE_CEILING:   next_rdata[15:0] = fine_ceiling_limit;
            drr_pkg::IDX_COARSE_FLOOR:   next_rdata[15:0] = coarse_floor_limit;
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= drr_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= is_mapped(s_axi_araddr[9:2]) ? drr_pkg::RESP_OKAY
                                                         : drr_pkg::RESP_DECERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ==========================================================
    // calibration and range selection
    logic [15:0]           fine_cal;
    logic [15:0]           coarse_cal;
    logic [15:0]           fine_lim;
    logic [15:0]           coarse_lim;
    logic [15:0]           fine_sh;
    logic [15:0]           coarse_sh;
    logic [2:0]            fine_shift;
    logic [2:0]            coarse_shift;
    logic [15:0]           fine_max;
    logic [15:0]           coarse_min;
    logic                  xover_en;
    drr_pkg::drr_range_type range_state;
    drr_pkg::drr_range_type next_range;
    logic [15:0]           next_value;

    drr_cal_unit fine_cal_unit
    (
        .raw    (fine_raw),
        .gain   (fine_range_gain),
        .offset (fine_range_offset),
        .cal    (fine_cal)
    );

    drr_cal_unit coarse_cal_unit
    (
        .raw    (coarse_raw),
        .gain   (coarse_range_gain),
        .offset (coarse_range_offset),
        .cal    (coarse_cal)
    );

    assign xover_en     = received_signal_strength_range_config[drr_pkg::XOVER_EN_BIT];
    assign fine_shift   = shift_count_config[drr_pkg::FINE_SHIFT_LSB +: 3];
    assign coarse_shift = shift_count_config[drr_pkg::COARSE_SHIFT_LSB +: 3];
    assign fine_max     = drr_pkg::FINE_MAX[fine_shift];
    assign coarse_min   = drr_pkg::COARSE_MIN[fine_shift];

    always_comb
    begin
        // limits act on the unshifted calibrated value
        fine_lim   = (fine_cal > fine_ceiling_limit) ? fine_ceiling_limit : fine_cal;
        coarse_lim = (coarse_cal < coarse_floor_limit) ? coarse_floor_limit : coarse_cal;
        if (xover_en)
        begin
            fine_sh   = fine_lim >> fine_shift;
            coarse_sh = coarse_lim >> coarse_shift;
        end
        else
        begin
            fine_sh   = fine_cal >> fine_shift;
            coarse_sh = coarse_cal >> fine_shift;
        end
    end

    always_comb
    begin
        if (received_signal_strength_range_config[drr_pkg::FORCE_FINE_BIT])
            next_range = drr_pkg::RANGE_FINE;
        else if (received_signal_strength_range_config[drr_pkg::FORCE_COARSE_BIT])
            next_range = drr_pkg::RANGE_COARSE;
        else if (xover_en)
            // no memory of the previous range, so the switch is a hard crossover
            next_range = (fine_cal >= fine_ceiling_limit) ? drr_pkg::RANGE_COARSE
                                                          : drr_pkg::RANGE_FINE;
        else
        begin
            unique case (range_state)
                drr_pkg::RANGE_FINE:
                    next_range = (fine_sh >= fine_max) ? drr_pkg::RANGE_COARSE
                                                       : drr_pkg::RANGE_FINE;
                drr_pkg::RANGE_COARSE:
                    next_range = (coarse_sh < coarse_min) ? drr_pkg::RANGE_FINE
                                                          : drr_pkg::RANGE_COARSE;
            endcase
        end
    end

    always_comb
    begin
        if (next_range == drr_pkg::RANGE_FINE)
            next_value = fine_sh;
        else if (!xover_en && coarse_sh < coarse_min)
            next_value = coarse_min;
        else
            next_value = coarse_sh;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            range_state <= drr_pkg::RANGE_FINE;
        else if (conv_valid)
            range_state <= next_range;
    end

    // value loaded only after shifting, so the measured value register holds the shifted result
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            result_value <= 16'h0000;
            result_valid <= 1'b0;
        end
        else
        begin
            result_valid <= conv_valid;
            if (conv_valid)
                result_value <= next_value;
        end
    end

    assign received_signal_strength_range_indicator = (range_state == drr_pkg::RANGE_COARSE);

    // a conversion landing on the clearing write still leaves the flag set
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            new_result <= 1'b0;
        else if (conv_valid)
            new_result <= 1'b1;
        else if (wr_fire && aw_index == drr_pkg::IDX_UPDATE_FLAGS && w_strb[0]
                 && w_data[drr_pkg::NEW_RESULT_BIT])
            new_result <= 1'b0;
    end

    // ==========================================================
    // assertions
    logic free_run;
    assign free_run = !received_signal_strength_range_config[drr_pkg::FORCE_FINE_BIT]
                   && !received_signal_strength_range_config[drr_pkg::FORCE_COARSE_BIT];

    result_timing_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid |=> result_valid && result_value == $past(next_value))
        else $error("result not loaded one cycle after conversion");

    xover_switch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid && xover_en && free_run
        |=> received_signal_strength_range_indicator == ($past(fine_cal) >= $past(fine_ceiling_limit)))
        else $error("crossover range does not follow ceiling compare");

    fine_shift_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid && xover_en && next_range == drr_pkg::RANGE_FINE
        |=> result_value == ($past(fine_lim) >> $past(fine_shift)))
        else $error("fine result not shifted by fine count");

    fine_ceiling_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid && xover_en && next_range == drr_pkg::RANGE_FINE
        |=> result_value <= $past(fine_ceiling_limit))
        else $error("fine result above ceiling");

    coarse_floor_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid && xover_en && next_range == drr_pkg::RANGE_COARSE
        |=> result_value == ($past(coarse_lim) >> $past(coarse_shift))
            && $past(coarse_lim) >= $past(coarse_floor_limit))
        else $error("coarse result below floor");

    hyst_up_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid && !xover_en && free_run && range_state == drr_pkg::RANGE_FINE
        && fine_sh >= fine_max |=> received_signal_strength_range_indicator)
        else $error("fine range kept at fine maximum");

    hyst_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid && !xover_en && free_run && range_state == drr_pkg::RANGE_COARSE
        && coarse_sh >= coarse_min |=> received_signal_strength_range_indicator)
        else $error("coarse range left above coarse minimum");

    coarse_min_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid && !xover_en && next_range == drr_pkg::RANGE_COARSE
        |=> result_value >= drr_pkg::COARSE_MIN[$past(fine_shift)])
        else $error("coarse result below table minimum");

    fine_max_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid && !xover_en && free_run && next_range == drr_pkg::RANGE_FINE
        |=> result_value < drr_pkg::FINE_MAX[$past(fine_shift)])
        else $error("fine result reported at or above fine maximum");

    new_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_valid |=> new_result ##1 (new_result || $past(wr_fire)))
        else $error("new result flag lost");
endmodule

// File: drr_readout_bench.sv
// self-checking bench for the dual-range signal strength readout
`timescale 1ns/10ps
`define CHECK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module drr_readout_bench;
    // ==========================================================
    // stimulus and observed signals
    logic        ref_clk       = 1'h0;
    logic        sys_rst       = 1'h1;
    logic [9:0]  s_axi_awaddr  = 10'h000;
    logic        s_axi_awvalid = 1'h0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'h0;
    logic        s_axi_wvalid  = 1'h0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready  = 1'h0;
    logic [9:0]  s_axi_araddr  = 10'h000;
    logic        s_axi_arvalid = 1'h0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready  = 1'h0;
    logic [15:0] fine_raw      = 16'h0;
    logic [15:0] coarse_raw    = 16'h0;
    logic        conv_valid    = 1'h0;
    logic [15:0] result_value;
    logic        result_valid;
    logic        received_signal_strength_range_indicator;
    int          n_errors      = 0;
    int          n_tests       = 0;

    drr_readout i_dut
    (
        .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fine_raw,
        .coarse_raw, .conv_valid, .result_value, .result_valid, .received_signal_strength_range_indicator
    );

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // bus and conversion tasks, entered right after a rising edge
    task automatic reg_write(input logic [7:0] idx, input logic [31:0] data,
                             input logic [1:0] resp);
        begin
            s_axi_awaddr  <= {idx, 2'h0};
            s_axi_wdata   <= data;
            s_axi_wstrb   <= 4'hF;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid  <= 1'h1;
            s_axi_bready  <= 1'h1;
            do
            begin
                @(posedge ref_clk);
                // each channel is released at the edge where it is taken
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
            end
            while (s_axi_bvalid !== 1'h1);
            s_axi_bready <= 1'h0;
            `CHECK(s_axi_bresp, resp)
            // idle edge so a following call never reasserts bready in this step
            @(posedge ref_clk);
        end
    endtask

    task automatic reg_read(input logic [7:0] idx, input logic [31:0] data,
                            input logic [1:0] resp);
        begin
            s_axi_araddr  <= {idx, 2'h0};
            s_axi_arvalid <= 1'h1;
            s_axi_rready  <= 1'h1;
            do
            begin
                @(posedge ref_clk);
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
            end
            while (s_axi_rvalid !== 1'h1);
            s_axi_rready <= 1'h0;
            `CHECK(s_axi_rdata, data)
            `CHECK(s_axi_rresp, resp)
            // idle edge so a following call never reasserts rready in this step
            @(posedge ref_clk);
        end
    endtask

    // outputs as they stand at the first edge after reset is released
    task automatic test_reset;
        begin
            `CHECK({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h7)
            `CHECK({s_axi_bvalid, s_axi_rvalid, result_valid}, 3'h0)
            `CHECK({received_signal_strength_range_indicator, result_value}, 17'h00000)
        end
    endtask

    // one conversion; outputs are judged as sampled at the edge after the answer
    task automatic convert(input logic [15:0] f, input logic [15:0] c,
                           input logic [15:0] ev, input logic ei);
        begin
            fine_raw   <= f;
            coarse_raw <= c;
            conv_valid <= 1'h1;
            @(posedge ref_clk);
            conv_valid <= 1'h0;
            @(posedge ref_clk);
            `CHECK(result_valid, 1'h1)
            `CHECK(result_value, ev)
            `CHECK(received_signal_strength_range_indicator, ei)
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic test_registers;
        logic [7:0]  idx [8] = '{8'h98, 8'h9C, 8'hA8, 8'hAC, 8'h8B, 8'h8F, 8'hB0, 8'h68};
        logic [15:0] val [8] = '{16'h8000, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h0,
                                 16'hFFFF, 16'h0};
        begin
            for (int i = 0; i < 8; i++)
                reg_read(idx[i], {16'h0, val[i]}, drr_pkg::RESP_OKAY);
            reg_read(8'h00, 32'h0, drr_pkg::RESP_DECERR);
            reg_write(8'h01, 32'hFFFF, drr_pkg::RESP_DECERR);
            reg_write(8'h98, 32'h1234, drr_pkg::RESP_OKAY);
            reg_read(8'h98, 32'h1234, drr_pkg::RESP_OKAY);
            reg_read(8'h9C, 32'h8000, drr_pkg::RESP_OKAY);
            reg_write(8'h98, 32'h8000, drr_pkg::RESP_OKAY);
        end
    endtask

    // each shift count: stay fine below maximum, go coarse at it, hold, return
    task automatic test_hysteresis;
        logic [15:0] fmax [8] = '{16'hFFF8, 16'h7FFC, 16'h3FFE, 16'h1FFF,
                                  16'h0FFF, 16'h07FF, 16'h03FF, 16'h01FF};
        logic [15:0] cmin [8] = '{16'hF000, 16'h7800, 16'h3C00, 16'h1E00,
                                  16'h0F00, 16'h0780, 16'h03C0, 16'h01E0};
        begin
            for (int n = 0; n < 8; n++)
            begin
                reg_write(8'h8F, 32'(n), drr_pkg::RESP_OKAY);
                convert((fmax[n] - 16'h1) << n, 16'h0, fmax[n] - 16'h1, 1'h0);
                convert(fmax[n] << n, cmin[n] << n, cmin[n], 1'h1);
                convert(16'h0, cmin[n] << n, cmin[n], 1'h1);
                convert(16'h0, (cmin[n] - 16'h1) << n, 16'h0, 1'h0);
            end
        end
    endtask

    task automatic test_crossover;
        begin
            reg_write(8'h8B, 32'h4, drr_pkg::RESP_OKAY);
            reg_write(8'h8F, 32'h21, drr_pkg::RESP_OKAY);
            reg_write(8'hA8, 32'h10, drr_pkg::RESP_OKAY);
            reg_write(8'h9C, 32'h4000, drr_pkg::RESP_OKAY);
            reg_write(8'hB0, 32'h4000, drr_pkg::RESP_OKAY);
            reg_write(8'hB1, 32'h2000, drr_pkg::RESP_OKAY);
            convert(16'h1000, 16'h3000, 16'h0808, 1'h0);
            convert(16'h5000, 16'h3000, 16'h0800, 1'h1);
            reg_read(8'h68, 32'h0800, drr_pkg::RESP_OKAY);
            convert(16'h3FF0, 16'h6000, 16'h0C00, 1'h1);
            convert(16'h3FEF, 16'h6000, 16'h1FFF, 1'h0);
            reg_write(8'h8B, 32'h6, drr_pkg::RESP_OKAY);
            convert(16'h1000, 16'h3000, 16'h0800, 1'h1);
            reg_write(8'h8B, 32'h5, drr_pkg::RESP_OKAY);
            convert(16'h5000, 16'h3000, 16'h2000, 1'h0);
            reg_read(8'h6F, 32'h2, drr_pkg::RESP_OKAY);
            reg_write(8'h6F, 32'h2, drr_pkg::RESP_OKAY);
            reg_read(8'h6F, 32'h0, drr_pkg::RESP_OKAY);
        end
    endtask

    // ==========================================================
    // verdict
    task automatic complete_run;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #40000;
        n_errors++;
        complete_run;
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk);
        test_reset;
        test_registers;
        test_hysteresis;
        test_crossover;
        complete_run;
    end
endmodule
